// ---- logic/siu_pkg.sv ----
// package: register map, field layout, reset values and timing for the status interrupt unit
`default_nettype none
package siu_pkg;

    // ********************************************************
    // register map (6-bit register address, 16-bit data)
    // ********************************************************
    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 16;
    localparam int          GEN_W           = 16;
    localparam int          FLT_W           = 16;
    localparam logic [5:0]  ADDR_CONFIG     = 6'h02;
    localparam logic [5:0]  ADDR_FLT_RESP   = 6'h10;
    localparam logic [5:0]  ADDR_FLT_MASK   = 6'h1D;
    localparam logic [5:0]  ADDR_GEN_MASK   = 6'h1E;
    localparam logic [5:0]  ADDR_GENERAL_STATUS_REG = 6'h20;
    localparam logic [5:0]  ADDR_FLT_STATUS = 6'h21;

    // ********************************************************
    // field positions and reset values
    // ********************************************************
    localparam int          CFG_LVL_BIT     = 0;
    localparam int          CFG_POL_BIT     = 1;
    localparam int          CFG_PIN_EN_BIT  = 2;
    localparam int          CFG_W           = 3;
    localparam logic [2:0]  CFG_RESET       = 3'h1;
    localparam logic [15:0] MASK_RESET      = 16'hFFFF;
    localparam logic [15:0] FLT_RESP_RESET  = 16'h8020;
    localparam int          REF_SET_LSB     = 0;
    localparam int          REF_SET_W       = 2;
    localparam int          REF_FLT_BIT     = 0;

    // ********************************************************
    // timing: one internal oscillator period expressed in ref clocks
    // ********************************************************
    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          INT_PERIOD_NS   = 813;
    localparam int          INT_PERIOD_CYC  = (INT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          DIV_W           = 5;
    localparam logic [4:0]  DIV_LAST        = 5'(INT_PERIOD_CYC - 1);

    // ********************************************************
    // carriers
    // ********************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } siu_bus_req_t;

    typedef struct packed {
        logic       pin_en;
        logic       active_high;
        logic       level_sel;
    } siu_cfg_t;

    typedef struct packed {
        logic [GEN_W-1:0]     gen_mask;
        logic [FLT_W-1:0]     flt_mask;
        logic [GEN_W-1:0]     gen_sticky;
        logic [FLT_W-1:0]     flt_sticky;
        logic [GEN_W-1:0]     gen_prev;
        logic [FLT_W-1:0]     flt_prev;
        siu_cfg_t             cfg;
        logic [DATA_W-1:0]    resp;
        logic [DATA_W-1:0]    rdata;
        logic [DIV_W-1:0]     div_cnt;
        logic                 pend;
        logic                 pulse;
        logic [REF_SET_W-1:0] ref_act;
    } siu_state_t;

endpackage
`default_nettype wire

// ---- logic/siu_status_interrupt_unit.sv ----
// module: status interrupt unit with sticky status, masks, edge or level interrupt pin and alarm pin
//
// Overview of operation
// RULE_01 - Interrupts come only from the general status register and the fault status register, each with its own mask.
// RULE_02 - A mask bit of 1 blocks its status bit from the interrupt, a 0 lets it through.
// RULE_03 - Both mask registers reset to all ones so nothing interrupts until software unmasks it.
// RULE_04 - Reading a status register clears sticky bits whose condition has gone and keeps those still present.
// RULE_05 - The level-select bit picks level signalling when 1 (its reset value) and edge signalling when 0.
// RULE_06 - In edge mode each qualifying event gives a pulse one internal oscillator period wide; the code merges close events, stretching a running pulse.
// RULE_07 - In level mode the interrupt stays asserted until the condition is gone and the status is read.
// RULE_08 - The polarity bit makes the interrupt pin active high when 1 and active low when 0.
// RULE_09 - The edge path adds up to one internal clock period of latency, the level path is combinational.
// RULE_10 - Each status bit makes a one-shot event on assertion that drives the edge interrupt.
// RULE_11 - The general and fault interrupts are each the OR of their own register's unmasked status bits.
// RULE_12 - In level mode unmasking an already set sticky bit asserts the interrupt at once.
// RULE_13 - In edge mode only an event after unmasking raises an interrupt, not an older sticky bit.
// RULE_14 - Every interrupt is held in a status register, drives the pin when enabled and fault ones drive the alarm pin.
// RULE_15 - An invalid reference sets a fault bit and the output response follows the reference-fault setting at 10h.
// RULE_16 - Fault output actions use fault status and the response setting only, never the fault mask.
// RULE_17 - A status read in the same cycle as a new assertion keeps that bit set.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module siu_status_interrupt_unit (
    input  wire logic                                    i_ref_clk,
    input  wire logic                                    i_rst_n,
    input  wire siu_pkg::siu_bus_req_t                   i_bus,
    output logic [siu_pkg::DATA_W-1:0]                   o_rdata,
    input  wire logic [siu_pkg::GEN_W-1:0]               i_gen_cond,
    input  wire logic [siu_pkg::FLT_W-1:0]               i_flt_cond,
    input  wire logic                                    i_ref_invalid,
    output logic                                         o_irq_pin,
    output logic                                         o_irq_oe,
    output logic                                         o_alarm_n,
    output logic                                         o_int,
    output logic [siu_pkg::REF_SET_W-1:0]                o_ref_fault_action
);

    // ********************************************************
    // helpers
    // ********************************************************

    // next sticky value: a live condition or a fresh event always wins over a clear
    function automatic logic [15:0] sticky_next(
        input logic [15:0] cur,
        input logic [15:0] cond,
        input logic [15:0] clr
    );
        sticky_next = (cur & ~clr) | cond; // RULE_04 RULE_17
    endfunction

    // any unmasked bit set
    function automatic logic any_unmasked(
        input logic [15:0] bits,
        input logic [15:0] mask
    );
        any_unmasked = |(bits & ~mask); // RULE_02 RULE_11
    endfunction

    // ********************************************************
    // state
    // ********************************************************
    siu_pkg::siu_state_t st_ff;
    siu_pkg::siu_state_t nxt_st;

    logic [siu_pkg::FLT_W-1:0] flt_cond;
    logic [siu_pkg::GEN_W-1:0] gen_event;
    logic [siu_pkg::FLT_W-1:0] flt_event;
    logic                      new_event;
    logic                      tick;
    logic                      general_interrupt_or;
    logic                      flt_irq;
    logic                      level_act;
    logic                      irq_act;
    logic                      rd_gen;
    logic                      rd_flt;

    // the reference monitor feeds the reference fault bit alongside its own condition
    always_comb begin
        flt_cond                       = i_flt_cond;
        flt_cond[siu_pkg::REF_FLT_BIT] = i_flt_cond[siu_pkg::REF_FLT_BIT] | i_ref_invalid; // RULE_15
    end

    // one-shot events on assertion, so simultaneous events never hide each other
    assign gen_event = i_gen_cond & ~st_ff.gen_prev; // RULE_10
    assign flt_event = flt_cond & ~st_ff.flt_prev;   // RULE_10

    // only events whose mask is open now count, an older sticky bit does not
    assign new_event = any_unmasked(gen_event, st_ff.gen_mask) | any_unmasked(flt_event, st_ff.flt_mask); // RULE_13

    // internal oscillator period tick from the reference clock divider
    assign tick = (st_ff.div_cnt == siu_pkg::DIV_LAST);

    assign rd_gen = i_bus.rd & (i_bus.addr == siu_pkg::ADDR_GENERAL_STATUS_REG);
    assign rd_flt = i_bus.rd & (i_bus.addr == siu_pkg::ADDR_FLT_STATUS);

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        logic [15:0] gen_clr;
        logic [15:0] flt_clr;
        gen_clr = '0;
        flt_clr = '0;
        nxt_st  = st_ff;

        // register writes; status bits also clear on a written one
        if (i_bus.wr) begin
            case (i_bus.addr)
                siu_pkg::ADDR_CONFIG: begin
                    nxt_st.cfg = siu_pkg::siu_cfg_t'(i_bus.wdata[siu_pkg::CFG_W-1:0]); // RULE_05 RULE_08
                end
                siu_pkg::ADDR_FLT_RESP: begin
                    nxt_st.resp = i_bus.wdata;
                end
                siu_pkg::ADDR_FLT_MASK: begin
                    nxt_st.flt_mask = i_bus.wdata; // RULE_01
                end
                siu_pkg::ADDR_GEN_MASK: begin
                    nxt_st.gen_mask = i_bus.wdata; // RULE_01
                end
                siu_pkg::ADDR_GENERAL_STATUS_REG: begin
                    gen_clr = i_bus.wdata;
                end
                siu_pkg::ADDR_FLT_STATUS: begin
                    flt_clr = i_bus.wdata;
                end
                default: begin
                    gen_clr = '0;
                end
            endcase
        end

        // reads clear every sticky bit whose condition has ended
        if (rd_gen) begin
            gen_clr = '1; // RULE_04
        end
        if (rd_flt) begin
            flt_clr = '1; // RULE_04
        end

        nxt_st.gen_sticky = sticky_next(st_ff.gen_sticky, i_gen_cond, gen_clr); // RULE_14 RULE_17
        nxt_st.flt_sticky = sticky_next(st_ff.flt_sticky, flt_cond, flt_clr);   // RULE_14 RULE_17
        nxt_st.gen_prev   = i_gen_cond;
        nxt_st.flt_prev   = flt_cond;

        // read data stands for exactly the cycle after the strobe; unmapped reads return zero
        nxt_st.rdata = '0;
        if (i_bus.rd) begin
            case (i_bus.addr)
                siu_pkg::ADDR_CONFIG:     nxt_st.rdata = {13'h0000, st_ff.cfg};
                siu_pkg::ADDR_FLT_RESP:   nxt_st.rdata = st_ff.resp;
                siu_pkg::ADDR_FLT_MASK:   nxt_st.rdata = st_ff.flt_mask;
                siu_pkg::ADDR_GEN_MASK:   nxt_st.rdata = st_ff.gen_mask;
                siu_pkg::ADDR_GENERAL_STATUS_REG: nxt_st.rdata = st_ff.gen_sticky;
                siu_pkg::ADDR_FLT_STATUS: nxt_st.rdata = st_ff.flt_sticky;
                default:                  nxt_st.rdata = '0;
            endcase
        end

        // divider for the internal clock period
        if (tick) begin
            nxt_st.div_cnt = '0;
        end else begin
            nxt_st.div_cnt = st_ff.div_cnt + 5'h01;
        end

        // edge path: events wait for the next internal tick, then the pulse stands one period
        // a pulse already running absorbs events of its own period, a limitation the host must accept
        if (tick) begin
            nxt_st.pulse = st_ff.pend | new_event; // RULE_06 RULE_09
            nxt_st.pend  = 1'b0;
        end else if (new_event) begin
            nxt_st.pend  = 1'b1; // RULE_09
        end

        // fault action follows fault status and the response setting, never the mask
        if (nxt_st.flt_sticky[siu_pkg::REF_FLT_BIT]) begin
            nxt_st.ref_act = nxt_st.resp[siu_pkg::REF_SET_LSB +: siu_pkg::REF_SET_W]; // RULE_15 RULE_16
        end else begin
            nxt_st.ref_act = '0; // RULE_16
        end
    end

    // ********************************************************
    // state register
    // ********************************************************

    // masks come up closed so nothing fires before software opens them
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_ff            <= '0;
            st_ff.gen_mask   <= siu_pkg::MASK_RESET; // RULE_03
            st_ff.flt_mask   <= siu_pkg::MASK_RESET; // RULE_03
            st_ff.cfg        <= siu_pkg::siu_cfg_t'(siu_pkg::CFG_RESET); // RULE_05
            st_ff.resp       <= siu_pkg::FLT_RESP_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************************************************
    // outputs
    // ********************************************************

    // level path is purely combinational from the sticky bits, so unmasking acts at once
    assign general_interrupt_or   = any_unmasked(st_ff.gen_sticky, st_ff.gen_mask); // RULE_11
    assign flt_irq   = any_unmasked(st_ff.flt_sticky, st_ff.flt_mask); // RULE_11
    assign level_act = general_interrupt_or | flt_irq;                                // RULE_07 RULE_12
    assign irq_act   = st_ff.cfg.level_sel ? level_act : st_ff.pulse;    // RULE_05

    assign o_irq_pin          = st_ff.cfg.active_high ? irq_act : ~irq_act; // RULE_08
    assign o_irq_oe           = st_ff.cfg.pin_en;                           // RULE_14
    assign o_alarm_n          = ~flt_irq;                                   // RULE_14
    assign o_int              = level_act;
    assign o_rdata            = st_ff.rdata;
    assign o_ref_fault_action = st_ff.ref_act;

    // ********************************************************
    // checks
    // ********************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_pulse_start;
        $rose(st_ff.pulse);
    endsequence

    sequence s_edge_event;
        !st_ff.cfg.level_sel && new_event;
    endsequence

    // half an internal period of pulse; two halves and one cycle make 17
    sequence s_pulse_half;
        (st_ff.pulse)[*8];
    endsequence

    // half an internal period without a tick
    sequence s_no_tick_half;
        (!tick)[*8];
    endsequence

    // closed masks keep both the interrupt and the alarm quiet
    chk_masks_block: assert property ((&st_ff.gen_mask && &st_ff.flt_mask) |-> !o_int && o_alarm_n) // RULE_02
        else $error("closed masks still let an interrupt through");

    // a present condition can never be cleared away
    chk_sticky_hold: assert property (|i_gen_cond |=> (st_ff.gen_sticky & $past(i_gen_cond)) == $past(i_gen_cond)) // RULE_17
        else $error("general sticky bit lost while its condition was present");

    // a read with every condition gone empties the register
    chk_read_clear: assert property ((rd_gen && i_gen_cond == 16'h0000) |=> st_ff.gen_sticky == 16'h0000) // RULE_04
        else $error("general status read did not clear ended conditions");

    // first half of the pulse; the full span is checked further down
    chk_edge_width: assert property (s_pulse_start |-> (st_ff.pulse && !tick)[*8]) // RULE_06
        else $error("edge pulse shorter than one internal period");

    // the pulse only moves on the internal period tick
    chk_pulse_tick: assert property ($changed(st_ff.pulse) |-> $past(tick)) // RULE_06
        else $error("edge pulse changed off the internal tick");

    // worst case is an event just after a tick
    chk_edge_latency: assert property (s_edge_event |-> ##[1:17] st_ff.pulse) // RULE_09
        else $error("edge interrupt did not follow the event within one period");

    // level mode shows the interrupt at the selected polarity
    chk_level_polarity: assert property ((st_ff.cfg.level_sel && level_act) |-> o_irq_pin == st_ff.cfg.active_high) // RULE_08
        else $error("level interrupt pin not at its active level");

    // an unmasked fault shows on both the alarm and the interrupt
    chk_alarm_pin: assert property (flt_irq |-> !o_alarm_n && o_int) // RULE_14
        else $error("unmasked fault did not drive the alarm pin");

    // the action follows the setting whatever the fault mask holds
    chk_ref_action: assert property (st_ff.flt_sticky[0] |-> o_ref_fault_action == st_ff.resp[1:0]) // RULE_16
        else $error("reference fault action not taken from the response setting");

    // the reference monitor feeds fault bit 0
    chk_ref_fault: assert property (i_ref_invalid |=> st_ff.flt_sticky[0]) // RULE_15
        else $error("invalid reference did not set the fault bit");

    // ********************************************************
    // edge path checks
    // ********************************************************

    // the pulse stands the whole 17-cycle internal period
    chk_edge_full: assert property ( // RULE_06
        s_pulse_start
        |-> s_pulse_half ##1 s_pulse_half ##1 st_ff.pulse)
        else $error("edge pulse ended before the internal period");

    // ticks come exactly one internal period apart
    chk_tick_period: assert property ( // RULE_06
        tick
        |=> s_no_tick_half ##1 s_no_tick_half ##1 tick)
        else $error("internal tick period wrong");

    // an event between ticks is held so that it is never dropped
    chk_pend_set: assert property ( // RULE_09
        (new_event && !tick)
        |=> st_ff.pend)
        else $error("edge event not held for the next tick");

    // a held event waits for the tick and nothing else
    chk_pend_keep: assert property ( // RULE_09
        (st_ff.pend && !tick)
        |=> st_ff.pend)
        else $error("held edge event lost before the tick");

    // the tick turns a held event into the pulse
    chk_pend_fire: assert property ( // RULE_10
        (tick && st_ff.pend)
        |=> st_ff.pulse && !st_ff.pend)
        else $error("held edge event did not start a pulse");

    // no pulse without a fresh unmasked event, so an old sticky bit stays quiet
    chk_no_stale: assert property ( // RULE_13
        (tick && !st_ff.pend && !new_event)
        |=> !st_ff.pulse)
        else $error("edge pulse without a new event");

    // between pulses the pin rests at its inactive level
    chk_edge_idle: assert property ( // RULE_08
        (!st_ff.cfg.level_sel && !st_ff.pulse)
        |-> o_irq_pin != st_ff.cfg.active_high)
        else $error("edge mode pin active without a pulse");

    // in edge mode the pin follows the pulse
    chk_edge_active: assert property ( // RULE_05
        (!st_ff.cfg.level_sel && st_ff.pulse)
        |-> o_irq_pin == st_ff.cfg.active_high)
        else $error("edge mode pin not active during the pulse");

    // ********************************************************
    // level, status and fault checks
    // ********************************************************

    // the pulse also runs in level mode and must never reach the pin there
    chk_level_only: assert property ( // RULE_05
        (st_ff.cfg.level_sel && !level_act)
        |-> o_irq_pin != st_ff.cfg.active_high)
        else $error("level mode pin active without a level");

    // with no read and no write an asserted level stays up
    chk_level_hold: assert property ( // RULE_07
        (st_ff.cfg.level_sel && level_act && !i_bus.wr && !i_bus.rd)
        |=> level_act)
        else $error("level interrupt dropped without a read");

    // opening a mask over a set sticky bit raises the interrupt next cycle
    chk_unmask_now: assert property ( // RULE_12
        (i_bus.wr && i_bus.addr == siu_pkg::ADDR_GEN_MASK && |(st_ff.gen_sticky & ~i_bus.wdata))
        |=> general_interrupt_or)
        else $error("unmasked sticky bit did not interrupt");

    // a fault read with every condition gone empties the register
    chk_flt_clear: assert property ( // RULE_04
        (rd_flt && flt_cond == 16'h0000)
        |=> st_ff.flt_sticky == 16'h0000)
        else $error("fault status read did not clear ended conditions");

    // writing ones clears ended fault bits just as a read does
    chk_w1c_clear: assert property ( // RULE_04
        (i_bus.wr && i_bus.addr == siu_pkg::ADDR_FLT_STATUS && flt_cond == 16'h0000)
        |=> (st_ff.flt_sticky & $past(i_bus.wdata)) == 16'h0000)
        else $error("fault status write of ones did not clear");

    // a present fault condition can never be cleared away
    chk_flt_hold: assert property ( // RULE_17
        |flt_cond
        |=> (st_ff.flt_sticky & $past(flt_cond)) == $past(flt_cond))
        else $error("fault sticky bit lost while its condition was present");

    // with the reference fault gone the output action is released
    chk_action_off: assert property ( // RULE_16
        !st_ff.flt_sticky[siu_pkg::REF_FLT_BIT]
        |-> o_ref_fault_action == 2'h0)
        else $error("reference fault action held without a fault");

endmodule
`default_nettype wire

// ---- sim/siu_host_model.sv ----
// host controller model: watches the interrupt pin and measures each pulse
`timescale 1ns/1ps
`default_nettype none
module siu_host_model (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_pin,
    input  wire logic i_oe,
    input  wire logic i_active_high,
    output var  int   o_pulses,
    output var  int   o_width
);
    logic act;
    logic act_q;
    int   run;

    // a pin that is not driven is never read as active
    assign act = i_oe && (i_pin === i_active_high);

    // count rising active levels and hold the width of the last pulse
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pulses <= 0;
            o_width  <= 0;
            run      <= 0;
            act_q    <= 1'b0;
        end else begin
            act_q <= act;
            run   <= act ? run + 1 : 0;
            if (act && !act_q) o_pulses <= o_pulses + 1;
            if (!act && act_q) o_width <= run;
        end
    end
endmodule
`default_nettype wire

// ---- sim/siu_testbench.sv ----
// testbench: directed scenarios for the status interrupt unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                  i_ref_clk = 1'b0;
    logic                  i_rst_n   = 1'b0;
    siu_pkg::siu_bus_req_t bus       = '0;
    logic [15:0]           gen_c     = 16'h0000;
    logic [15:0]           flt_c     = 16'h0000;
    logic                  ref_bad   = 1'b0;
    logic                  act_hi    = 1'b0;
    logic [15:0]           rdata;
    logic [15:0]           d;
    logic                  pin;
    logic                  oe;
    logic                  alarm_n;
    logic                  irq;
    logic [1:0]            action;
    int                    n_pulse;
    int                    width;
    int                    err_count = 0;
    int                    n_checks  = 0;

    // 20 MHz reference clock
    always #25 i_ref_clk = ~i_ref_clk;

    siu_status_interrupt_unit dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
        .i_gen_cond(gen_c), .i_flt_cond(flt_c), .i_ref_invalid(ref_bad), .o_irq_pin(pin), .o_irq_oe(oe),
        .o_alarm_n(alarm_n), .o_int(irq), .o_ref_fault_action(action));

    siu_host_model host (.i_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_pin(pin), .i_oe(oe),
        .i_active_high(act_hi), .o_pulses(n_pulse), .o_width(width));

    // ********************************************************
    // bus cycles and comparison
    // ********************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // strobe is released at the taking edge, so the next call leaves a gap
    task automatic wr(input logic [5:0] a, input logic [15:0] v);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge i_ref_clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [5:0] a);
        @(posedge i_ref_clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge i_ref_clk);
        bus <= '0;
        #1 d = rdata;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset;
        chk("pin idle", 16'h0001, {15'h0, pin});
        rd(siu_pkg::ADDR_GEN_MASK); chk("gen mask", 16'hFFFF, d);
        rd(siu_pkg::ADDR_FLT_MASK); chk("flt mask", 16'hFFFF, d);
        rd(siu_pkg::ADDR_CONFIG); chk("config", 16'h0001, d);
        rd(siu_pkg::ADDR_FLT_RESP); chk("flt resp", siu_pkg::FLT_RESP_RESET, d);
        rd(6'h3F); chk("unmapped", 16'h0000, d);
        @(posedge i_ref_clk) gen_c <= 16'hFFFF;
        cyc(3); chk("masked int", 16'h0000, {15'h0, irq});
        @(posedge i_ref_clk) gen_c <= 16'h0000;
        rd(siu_pkg::ADDR_GENERAL_STATUS_REG); chk("general_status_reg", 16'hFFFF, d);
        rd(siu_pkg::ADDR_GENERAL_STATUS_REG); chk("gen cleared", 16'h0000, d);
    endtask

    task automatic t_level;
        wr(siu_pkg::ADDR_GEN_MASK, 16'hFFFE);
        @(posedge i_ref_clk) gen_c <= 16'h0003;
        cyc(2); chk("int set", 16'h0001, {15'h0, irq});
        chk("pin low", 16'h0000, {15'h0, pin});
        @(posedge i_ref_clk) gen_c <= 16'h0002;
        cyc(3); chk("int held", 16'h0001, {15'h0, irq});
        rd(siu_pkg::ADDR_GENERAL_STATUS_REG); chk("status", 16'h0003, d);
        cyc(1); chk("int gone", 16'h0000, {15'h0, irq});
        rd(siu_pkg::ADDR_GENERAL_STATUS_REG); chk("persist", 16'h0002, d);
        wr(siu_pkg::ADDR_GEN_MASK, 16'hFFFC);
        cyc(1); chk("unmask int", 16'h0001, {15'h0, irq});
        // new assertion lands on the very edge that takes the read
        @(posedge i_ref_clk);
        bus <= '{addr: siu_pkg::ADDR_GENERAL_STATUS_REG, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        gen_c <= 16'h0004;
        @(posedge i_ref_clk);
        bus <= '0;
        gen_c <= 16'h0000;
        cyc(2);
        rd(siu_pkg::ADDR_GENERAL_STATUS_REG); chk("kept", 16'h0004, d);
        wr(siu_pkg::ADDR_GEN_MASK, 16'hFFFF);
    endtask

    task automatic t_fault;
        wr(siu_pkg::ADDR_FLT_RESP, 16'h0003);
        @(posedge i_ref_clk) ref_bad <= 1'b1;
        cyc(3); chk("action", 16'h0003, {14'h0, action});
        chk("alarm masked", 16'h0001, {15'h0, alarm_n});
        wr(siu_pkg::ADDR_FLT_MASK, 16'hFFFE);
        cyc(1); chk("alarm", 16'h0000, {15'h0, alarm_n});
        chk("flt int", 16'h0001, {15'h0, irq});
        @(posedge i_ref_clk) ref_bad <= 1'b0;
        cyc(2);
        rd(siu_pkg::ADDR_FLT_STATUS); chk("flt status", 16'h0001, d);
        cyc(1); chk("alarm off", 16'h0001, {15'h0, alarm_n});
        chk("action off", 16'h0000, {14'h0, action});
        wr(siu_pkg::ADDR_FLT_MASK, 16'hFFFF);
        // write-one clear: a live condition survives it, an ended one does not
        @(posedge i_ref_clk) flt_c <= 16'h0010;
        cyc(2);
        wr(siu_pkg::ADDR_FLT_STATUS, 16'h0010);
        rd(siu_pkg::ADDR_FLT_STATUS); chk("w1c live", 16'h0010, d);
        @(posedge i_ref_clk) flt_c <= 16'h0000;
        wr(siu_pkg::ADDR_FLT_STATUS, 16'h0010);
        rd(siu_pkg::ADDR_FLT_STATUS); chk("w1c gone", 16'h0000, d);
    endtask

    task automatic t_edge;
        act_hi <= 1'b1;
        wr(siu_pkg::ADDR_CONFIG, 16'h0006);
        cyc(1); chk("pin enable", 16'h0001, {15'h0, oe});
        chk("pin idle hi", 16'h0000, {15'h0, pin});
        @(posedge i_ref_clk) gen_c <= 16'h0002;
        cyc(3);
        wr(siu_pkg::ADDR_GEN_MASK, 16'hFFF9);
        cyc(40); chk("old sticky", 16'h0000, n_pulse[15:0]);
        @(posedge i_ref_clk) gen_c <= 16'h0006;
        cyc(40); chk("one pulse", 16'h0001, n_pulse[15:0]);
        chk("width", 16'(siu_pkg::INT_PERIOD_CYC), width[15:0]);
        @(posedge i_ref_clk) gen_c <= 16'h0000;
        cyc(2);
        @(posedge i_ref_clk) gen_c <= 16'h0004;
        cyc(40); chk("second", 16'h0002, n_pulse[15:0]);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reset for two cycles, then the scenarios in turn
    initial begin
        repeat (2) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        cyc(1);
        t_reset;
        t_level;
        t_fault;
        t_edge;
        results;
    end

    // the scenarios need well under a thousand cycles
    initial begin
        #(50 * 4000);
        err_count++;
        results;
    end
endmodule
`default_nettype wire
